// [dv/spi_master_model.sv]
`timescale 1ns/1ps
module spi_master_model (
	input wire logic clock,
	input wire logic miso,
	output logic sclk,
	output logic mosi,
	output logic select_low
);
	logic cpol = 1'b0;
	initial begin
		sclk = 1'b0;
		mosi = 1'b1;
		select_low = 1'b1;
	end
	// idle level of sclk: 0 for mode 0, 1 for mode 3; only changed between frames
	task automatic set_mode(input logic m);
		@(negedge clock);
		cpol = m;
		sclk = m;
	endtask
	// frame of n bytes, opcode first, msb first; sclk stands at its idle level between frames
	task automatic frame(input logic [23:0] tx, input int n, output logic [23:0] rx);
		rx = '0;
		@(negedge clock);
		select_low = 1'b0;
		for (int i = 0; i < 8 * n; i++) begin
			if (cpol) sclk = 1'b0;
			mosi = tx[23 - i];
			repeat (10) @(negedge clock);
			rx[23 - i] = miso;
			sclk = 1'b1;
			repeat (10) @(negedge clock);
			if (!cpol) sclk = 1'b0;
		end
		repeat (10) @(negedge clock);
		select_low = 1'b1;
		mosi = ~mosi; // stale data is not left on the line
		repeat (20) @(negedge clock);
	endtask
endmodule

// [dv/spi_status_props.sv]
`timescale 1ns/1ps
module spi_status_props (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic select_low,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic tristate_idle,
	input wire logic sensor_channel_enable,
	input wire logic register_channel_enable,
	input wire logic sensor_valid_flag,
	input wire logic sensor_latch,
	input wire spi_status_pkg::reg_req_t reg_req,
	input wire spi_status_pkg::reg_rsp_t reg_rsp
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// pulses: request strobe and sensor latch each stay low for 8 cycles after a pulse
	a_req_single_pulse: assert property (reg_req.strobe |=> !reg_req.strobe [*8])
		else $error("request strobe repeated");
	a_latch_single_pulse: assert property (sensor_latch |=> !sensor_latch [*8])
		else $error("sensor latch repeated");
	a_latch_on_rise: assert property (sensor_latch |-> sclk && !select_low)
		else $error("latch outside a rising serial clock");
	a_req_in_frame: assert property (reg_req.strobe |-> !select_low)
		else $error("request outside a frame");
	a_req_channel_on: assert property (reg_req.strobe |-> register_channel_enable)
		else $error("request with register channel off");
	a_req_fields_hold: assert property (reg_req.strobe |=>
		($stable(reg_req.addr) && $stable(reg_req.wdata)) [*4])
		else $error("request fields moved");
	// miso levels in and out of a frame
	a_drive_in_frame: assert property (!select_low [*6] |-> miso_oe)
		else $error("miso not driven while selected");
	a_idle_level: assert property ((select_low && $stable(tristate_idle)) [*8]
		|-> miso && (miso_oe == !tristate_idle))
		else $error("wrong idle level on miso");
	// with both channels off every byte is passed through
	a_echo_when_off: assert property ((!select_low && !sensor_channel_enable
		&& !register_channel_enable && $stable(mosi)) [*8] |-> miso == mosi)
		else $error("miso does not follow mosi");
endmodule
bind spi_status_slave spi_status_props props_u (.clock(clock), .reset_n(reset_n),
	.sclk(sclk), .mosi(mosi), .select_low(select_low), .miso(miso), .miso_oe(miso_oe),
	.tristate_idle(tristate_idle), .sensor_channel_enable(sensor_channel_enable),
	.register_channel_enable(register_channel_enable), .sensor_valid_flag(sensor_valid_flag),
	.sensor_latch(sensor_latch), .reg_req(reg_req), .reg_rsp(reg_rsp));

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic tristate_idle = 1'b1;
	logic sensor_channel_enable = 1'b1;
	logic register_channel_enable = 1'b1;
	logic sensor_valid_flag = 1'b1;
	logic sclk, mosi, select_low, miso, miso_oe, sensor_latch;
	spi_status_pkg::reg_req_t reg_req;
	spi_status_pkg::reg_rsp_t reg_rsp = '0;
	logic [7:0] mem [256];
	logic [8:0] dly = '0;
	logic [23:0] r;
	int n_fail = 0;
	int check_count = 0;
	int latches = 0;
	always #2 clock = ~clock;
	spi_status_slave dut_u (.clock(clock), .reset_n(reset_n), .sclk(sclk), .mosi(mosi),
		.select_low(select_low), .miso(miso), .miso_oe(miso_oe), .tristate_idle(tristate_idle),
		.sensor_channel_enable(sensor_channel_enable), .sensor_latch(sensor_latch),
		.register_channel_enable(register_channel_enable), .reg_req(reg_req),
		.sensor_valid_flag(sensor_valid_flag), .reg_rsp(reg_rsp));
	spi_master_model host_u (.clock(clock), .miso(miso), .sclk(sclk), .mosi(mosi),
		.select_low(select_low));
	// slow register file, so busy is still seen by the first poll
	always @(negedge clock) begin
		reg_rsp.done <= 1'b0;
		if (reg_req.strobe === 1'b1) dly <= 9'h0fa;
		else if (dly != 9'h000) dly <= dly - 9'h001;
		if (dly == 9'h001) begin
			if (reg_req.write) mem[reg_req.addr] <= reg_req.wdata;
			reg_rsp <= {1'b1, reg_req.addr == 8'hef, reg_req.addr == 8'hee, mem[reg_req.addr]};
		end
	end
	// count sensor latch pulses
	always @(posedge clock) if (sensor_latch === 1'b1) latches++;
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// repeat the status poll until busy clears, bounded
	task automatic poll_done(output logic [23:0] p);
		for (int i = 0; i < 4; i++) begin
			host_u.frame(24'had0000, 3, p);
			if (p[9] === 1'b0) return;
		end
		n_fail++;
		wrap_up();
	endtask
	// watchdog against a hang
	initial begin
		#400000;
		n_fail++;
		wrap_up();
	end
	initial begin
		repeat (2) @(negedge clock);
		check({22'h0, miso, miso_oe}, 24'h2);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
		host_u.frame(24'had0000, 3, r);
		check(r & 24'hffff00, 24'had0000);
		host_u.frame(24'hd2105a, 3, r);
		check(r, 24'hd2105a);
		host_u.frame(24'had0000, 3, r);
		check(r & 24'hffff00, 24'had0200);
		poll_done(r);
		check(r, 24'had015a);
		$display("write test done");
		host_u.frame(24'h971000, 2, r);
		check(r, 24'h971000);
		poll_done(r);
		check(r, 24'had015a);
		host_u.frame(24'h97ee00, 2, r);
		poll_done(r);
		check(r & 24'hffff00, 24'had0800);
		host_u.frame(24'h97ef00, 2, r);
		poll_done(r);
		check(r & 24'hffff00, 24'had0400);
		$display("read test done");
		// same read again with the serial clock idling high
		host_u.set_mode(1'b1);
		host_u.frame(24'h971000, 2, r);
		check(r, 24'h971000);
		poll_done(r);
		check(r, 24'had015a);
		host_u.set_mode(1'b0);
		$display("mode 3 test done");
		// unknown opcode: error shows at the next poll only
		host_u.frame(24'h330000, 1, r);
		check(r, 24'h330000);
		host_u.frame(24'had0000, 3, r);
		check(r & 24'hff8000, 24'had8000);
		host_u.frame(24'had0000, 3, r);
		check(r & 24'hff8000, 24'had0000);
		$display("error test done");
		// two sensor polls, then a read; the latch is skipped after each poll
		latches = 0;
		host_u.frame(24'hf50000, 2, r);
		check(r, 24'hf58000);
		sensor_valid_flag = 1'b0;
		host_u.frame(24'hf5ff00, 2, r);
		check(r, 24'hf57f00);
		host_u.frame(24'ha60000, 1, r);
		sensor_valid_flag = 1'b1;
		host_u.frame(24'had0000, 3, r);
		check(r & 24'hff8000, 24'had8000);
		check(24'(latches), 24'h2);
		$display("sensor test done");
		// channels off: everything echoes and the error is kept
		register_channel_enable = 1'b0;
		host_u.frame(24'had1234, 3, r);
		check(r, 24'had1234);
		sensor_channel_enable = 1'b0;
		host_u.frame(24'hf50f00, 2, r);
		check(r, 24'hf50f00);
		host_u.frame(24'hd2a5c3, 3, r);
		check(r, 24'hd2a5c3);
		register_channel_enable = 1'b1;
		sensor_channel_enable = 1'b1;
		host_u.frame(24'had0000, 3, r);
		check(r & 24'hff8000, 24'had8000);
		// channel select clears the register flags
		host_u.frame(24'hb00000, 1, r);
		host_u.frame(24'had0000, 3, r);
		check(r & 24'hff0f00, 24'had0000);
		tristate_idle = 1'b0;
		repeat (3) @(negedge clock);
		check({22'h0, miso, miso_oe}, 24'h3);
		$display("channel test done");
		wrap_up();
	end
endmodule

// [rtl/spi_status_pkg.sv]
package spi_status_pkg;

	// command opcodes, first byte of every transfer
	localparam logic [7:0] OP_SENSOR_POLL = 8'hf5;
	localparam logic [7:0] OP_SENSOR_READ = 8'ha6;
	localparam logic [7:0] OP_REG_READ = 8'h97;
	localparam logic [7:0] OP_REG_WRITE = 8'hd2;
	localparam logic [7:0] OP_REG_POLL = 8'had;
	localparam logic [7:0] OP_CHANNEL_SELECT = 8'hb0;

	// status byte field positions
	localparam int ST_ERROR_BIT = 7;
	localparam int ST_REJECT_BIT = 3;
	localparam int ST_FAIL_BIT = 2;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_VALID_BIT = 0;

	// position of this slave's valid bit in the returned poll byte
	localparam int SENSOR_VALID_POS = 7;

	// packet framing
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [1:0] BYTE_ADDR = 2'h1;
	localparam logic [1:0] BYTE_DATA = 2'h2;

	// reset values
	localparam logic [7:0] DATA_BYTE_RESET = 8'h00;
	localparam logic STATUS_FLAG_RESET = 1'b0;

	typedef enum logic [3:0] {
		PH_OPCODE = 4'h1,
		PH_ECHO = 4'h2,
		PH_SENSOR_VALID_FLAG = 4'h4,
		PH_STATUS = 4'h8
	} phase_t;

	// request to the internal register file
	typedef struct packed {
		logic strobe;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// answer from the internal register file
	typedef struct packed {
		logic done;
		logic fail;
		logic reject;
		logic [7:0] rdata;
	} reg_rsp_t;

	typedef struct packed {
		logic sclk_s1;
		logic sclk_s2;
		logic sclk_s3;
		logic mosi_s1;
		logic mosi_s2;
		logic sel_s1;
		logic sel_s2;
		logic sel_s3;
		phase_t phase;
		logic [2:0] bit_cnt;
		logic [1:0] byte_idx;
		logic [7:0] rx;
		logic [7:0] opcode;
		logic [7:0] addr;
		logic [7:0] tx;
		logic out_bit;
		logic out_en;
		logic skip_latch;
		logic first_edge;
		logic err_cur;
		logic error_flag;
		logic address_rejected_flag;
		logic fail_flag;
		logic busy_flag;
		logic valid_flag;
		logic last_write;
		logic [7:0] data_byte;
		logic latch_pulse;
		reg_req_t req;
	} state_t;

endpackage

// [rtl/spi_status_slave.sv]
`timescale 1ns/1ps
// Overview of operation
// - sensor poll with sensor channel on puts valid flag in the mosi-miso path
// - after a sensor poll, next transfer's first rising edge requests no sensor latch
// - valid flag reads 0 for invalid sensor data, 1 for valid
// - single slave: own valid bit sits at bit 7 of the poll byte
// - sensor data is always ready, so sensor read needs no prior poll
// - register read: opcode plus address byte, both echoed on miso at once
// - register write: opcode, address, data, all echoed on miso at once
// - status bit 7 is error: unknown opcode or invalid sensor data; 6..4 zero
// - status bits 3 reject, 2 fail, 1 busy, 0 data valid
// - every status flag is active high
// - reject, fail, busy and valid are refreshed on each register access
// - error reports any fault of the previous transfer, whatever the command
// - register poll echoes opcode, then sends status byte and one data byte
// - after read or write, valid tells whether the returned data byte is good
// - data byte holds read contents after a read, written byte after a write
// - after other opcodes the data byte content is undefined
// - modes 0 and 3, sample on rising edge, 8-bit msb-first, opcode first
// - opcodes f5 poll, 97 read, d2 write, b0 select, a6 sensor read, ad reg poll
// - register channel off: register commands set error, skip, and echo mosi
// - sensor channel off: sensor commands set error, skip, and echo mosi
module spi_status_slave (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic select_low,
	output logic miso,
	output logic miso_oe,
	input wire logic tristate_idle,
	input wire logic sensor_channel_enable,
	input wire logic register_channel_enable,
	input wire logic sensor_valid_flag,
	output logic sensor_latch,
	output spi_status_pkg::reg_req_t reg_req,
	input wire spi_status_pkg::reg_rsp_t reg_rsp
);

	spi_status_pkg::state_t state_reg;
	spi_status_pkg::state_t state_next;

	logic sclk_rise;
	logic sclk_fall;
	logic selected;
	logic sel_start;
	logic sel_end;
	logic [7:0] byte_in;
	logic [7:0] status_now;

	// assemble the status byte; reserved bits read as zero
	function automatic logic [7:0] status_byte(input spi_status_pkg::state_t s);
		logic [7:0] b;
		b = 8'h00;
		b[spi_status_pkg::ST_ERROR_BIT] = s.error_flag;
		b[spi_status_pkg::ST_REJECT_BIT] = s.address_rejected_flag;
		b[spi_status_pkg::ST_FAIL_BIT] = s.fail_flag;
		b[spi_status_pkg::ST_BUSY_BIT] = s.busy_flag;
		b[spi_status_pkg::ST_VALID_BIT] = s.valid_flag;
		return b;
	endfunction

	// is this one of the register channel commands
	function automatic logic is_reg_op(input logic [7:0] op);
		return (op == spi_status_pkg::OP_REG_READ) || (op == spi_status_pkg::OP_REG_WRITE)
			|| (op == spi_status_pkg::OP_REG_POLL);
	endfunction

	// edge finding looks only at the second and third stages
	assign sclk_rise = state_reg.sclk_s2 & ~state_reg.sclk_s3;
	assign sclk_fall = ~state_reg.sclk_s2 & state_reg.sclk_s3;
	assign selected = ~state_reg.sel_s2;
	assign sel_start = ~state_reg.sel_s2 & state_reg.sel_s3;
	assign sel_end = state_reg.sel_s2 & ~state_reg.sel_s3;
	assign byte_in = {state_reg.rx[6:0], state_reg.mosi_s2};
	assign status_now = status_byte(state_reg);

	// next-state logic for the whole slave
	always_comb begin
		state_next = state_reg;
		state_next.req.strobe = 1'b0;
		state_next.latch_pulse = 1'b0;

		// two-stage synchronisers for the sclk, mosi and select_low pins
		state_next.sclk_s1 = sclk;
		state_next.sclk_s2 = state_reg.sclk_s1;
		state_next.sclk_s3 = state_reg.sclk_s2;
		state_next.mosi_s1 = mosi;
		state_next.mosi_s2 = state_reg.mosi_s1;
		state_next.sel_s1 = select_low;
		state_next.sel_s2 = state_reg.sel_s1;
		state_next.sel_s3 = state_reg.sel_s2;

		// completion of an internal access; done only counts while busy
		if (reg_rsp.done && state_reg.busy_flag) begin
			state_next.busy_flag = 1'b0;
			state_next.fail_flag = reg_rsp.fail;
			state_next.address_rejected_flag = reg_rsp.reject;
			state_next.valid_flag = ~reg_rsp.fail & ~reg_rsp.reject;
			if (!state_reg.last_write) begin
				state_next.data_byte = reg_rsp.rdata;
			end
		end

		// frame start: fresh opcode, fresh error record
		if (sel_start) begin
			state_next.phase = spi_status_pkg::PH_OPCODE;
			state_next.bit_cnt = 3'h0;
			state_next.byte_idx = 2'h0;
			state_next.err_cur = 1'b0;
			state_next.first_edge = 1'b1;
		end

		if (!selected) begin
			// idle line: driven high, or released when sharing a bus
			state_next.out_bit = 1'b1;
			state_next.out_en = ~tristate_idle;
			if (sel_end) begin
				state_next.error_flag = state_reg.err_cur;
				state_next.phase = spi_status_pkg::PH_OPCODE;
				state_next.bit_cnt = 3'h0;
			end
		end else begin
			state_next.out_en = 1'b1;
			// straight echo of mosi while opcode or plain data is passing
			if (state_reg.phase == spi_status_pkg::PH_OPCODE
				|| state_reg.phase == spi_status_pkg::PH_ECHO) begin
				state_next.out_bit = state_reg.mosi_s2;
			end

			if (sclk_rise) begin
				// first rising edge of a frame latches the sensor, unless suppressed
				if (state_reg.first_edge) begin
					state_next.first_edge = 1'b0;
					state_next.latch_pulse = ~state_reg.skip_latch;
					state_next.skip_latch = 1'b0;
				end
				state_next.rx = byte_in;
				state_next.bit_cnt = state_reg.bit_cnt + 3'h1;

				if (state_reg.bit_cnt == spi_status_pkg::LAST_BIT) begin
					case (state_reg.phase)
						spi_status_pkg::PH_OPCODE: begin
							state_next.opcode = byte_in;
							state_next.byte_idx = spi_status_pkg::BYTE_ADDR;
							state_next.phase = spi_status_pkg::PH_ECHO;
							if (is_reg_op(byte_in) && !register_channel_enable) begin
								state_next.err_cur = 1'b1;
							end else begin
								case (byte_in)
									spi_status_pkg::OP_SENSOR_POLL: begin
										if (sensor_channel_enable) begin
											// one-bit register slips into the path
											state_next.phase = spi_status_pkg::PH_SENSOR_VALID_FLAG;
											state_next.out_bit = sensor_valid_flag;
											state_next.skip_latch = 1'b1;
										end else begin
											state_next.err_cur = 1'b1;
										end
									end
									spi_status_pkg::OP_SENSOR_READ: begin
										// data is ready at once, so no poll is needed first
										if (!sensor_channel_enable || !sensor_valid_flag) begin
											state_next.err_cur = 1'b1;
										end
									end
									spi_status_pkg::OP_REG_POLL: begin
										state_next.phase = spi_status_pkg::PH_STATUS;
										state_next.tx = status_now;
										state_next.out_bit = status_now[7];
									end
									spi_status_pkg::OP_REG_READ,
									spi_status_pkg::OP_REG_WRITE: begin
										state_next.phase = spi_status_pkg::PH_ECHO;
									end
									spi_status_pkg::OP_CHANNEL_SELECT: begin
										// a completing access still wins over this clear
										if (!(reg_rsp.done && state_reg.busy_flag)) begin
											state_next.fail_flag = 1'b0;
											state_next.valid_flag = 1'b0;
											state_next.busy_flag = 1'b0;
											state_next.address_rejected_flag = 1'b0;
										end
									end
									default: begin
										state_next.err_cur = 1'b1;
									end
								endcase
							end
						end
						spi_status_pkg::PH_ECHO: begin
							if (state_reg.byte_idx != 2'h3) begin
								state_next.byte_idx = state_reg.byte_idx + 2'h1;
							end
							// register traffic only runs with the channel on
							if (register_channel_enable && !state_reg.busy_flag) begin
								if (state_reg.opcode == spi_status_pkg::OP_REG_READ
									&& state_reg.byte_idx == spi_status_pkg::BYTE_ADDR) begin
									state_next.req.strobe = 1'b1;
									state_next.req.write = 1'b0;
									state_next.req.addr = byte_in;
									state_next.last_write = 1'b0;
									state_next.busy_flag = 1'b1;
									state_next.valid_flag = 1'b0;
									state_next.fail_flag = 1'b0;
									state_next.address_rejected_flag = 1'b0;
								end
								if (state_reg.opcode == spi_status_pkg::OP_REG_WRITE) begin
									if (state_reg.byte_idx == spi_status_pkg::BYTE_ADDR) begin
										state_next.addr = byte_in;
									end
									if (state_reg.byte_idx == spi_status_pkg::BYTE_DATA) begin
										state_next.req.strobe = 1'b1;
										state_next.req.write = 1'b1;
										state_next.req.addr = state_reg.addr;
										state_next.req.wdata = byte_in;
										state_next.last_write = 1'b1;
										state_next.data_byte = byte_in;
										state_next.busy_flag = 1'b1;
										state_next.valid_flag = 1'b0;
										state_next.fail_flag = 1'b0;
										state_next.address_rejected_flag = 1'b0;
									end
								end
							end
						end
						spi_status_pkg::PH_STATUS: begin
							if (state_reg.byte_idx == spi_status_pkg::BYTE_ADDR) begin
								// status done, the data byte follows
								state_next.byte_idx = spi_status_pkg::BYTE_DATA;
								state_next.tx = state_reg.data_byte;
								state_next.out_bit = state_reg.data_byte[7];
							end else begin
								state_next.phase = spi_status_pkg::PH_ECHO;
								state_next.out_bit = state_reg.mosi_s2;
							end
						end
						spi_status_pkg::PH_SENSOR_VALID_FLAG: begin
							state_next.phase = spi_status_pkg::PH_SENSOR_VALID_FLAG;
						end
						default: begin
							state_next.phase = spi_status_pkg::PH_OPCODE;
						end
					endcase
				end
			end

			// shift on falling edges; the edge right after a load is skipped
			if (sclk_fall && state_reg.bit_cnt != 3'h0) begin
				if (state_reg.phase == spi_status_pkg::PH_STATUS) begin
					state_next.out_bit = state_reg.tx[6];
					state_next.tx = {state_reg.tx[6:0], 1'b0};
				end
				if (state_reg.phase == spi_status_pkg::PH_SENSOR_VALID_FLAG) begin
					state_next.out_bit = state_reg.rx[0];
				end
			end
		end
	end

	// single state register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '{
				sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_s3: 1'b0,
				mosi_s1: 1'b0, mosi_s2: 1'b0,
				sel_s1: 1'b1, sel_s2: 1'b1, sel_s3: 1'b1,
				phase: spi_status_pkg::PH_OPCODE,
				bit_cnt: 3'h0, byte_idx: 2'h0,
				rx: 8'h00, opcode: 8'h00, addr: 8'h00, tx: 8'h00,
				out_bit: 1'b1, out_en: 1'b0,
				skip_latch: 1'b0, first_edge: 1'b0, err_cur: 1'b0,
				error_flag: spi_status_pkg::STATUS_FLAG_RESET,
				address_rejected_flag: spi_status_pkg::STATUS_FLAG_RESET,
				fail_flag: spi_status_pkg::STATUS_FLAG_RESET,
				busy_flag: spi_status_pkg::STATUS_FLAG_RESET,
				valid_flag: spi_status_pkg::STATUS_FLAG_RESET,
				last_write: 1'b0,
				data_byte: spi_status_pkg::DATA_BYTE_RESET,
				latch_pulse: 1'b0,
				req: '{strobe: 1'b0, write: 1'b0, addr: 8'h00, wdata: 8'h00}
			};
		end else begin
			state_reg <= state_next;
		end
	end

	// all outputs straight from the state register
	assign miso = state_reg.out_bit;
	assign miso_oe = state_reg.out_en;
	assign sensor_latch = state_reg.latch_pulse;
	assign reg_req = state_reg.req;

endmodule
